// file: tmr_chan.sv
// ----------------------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------------------
package tmr_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_CMPA  = 8'h08;
  localparam logic [7:0] OFF_CMPB  = 8'h0c;
  localparam logic [7:0] OFF_CAPT  = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;
  localparam logic [7:0] OFF_FORCE = 8'h18;
  localparam logic [7:0] OFF_PORT  = 8'h1c;
  localparam logic [2:0] OFF_HIGH_ZERO = 3'h0;

  // control word fields
  localparam int unsigned CTRL_WGM_LSB = 0;
  localparam int unsigned CTRL_ACTA_LSB = 4;
  localparam int unsigned CTRL_ACTB_LSB = 6;
  localparam int unsigned CTRL_RUN_BIT = 8;

  // flag word fields, write one to clear
  localparam int unsigned FLAG_OVF_BIT = 0;
  localparam int unsigned FLAG_MA_BIT  = 1;
  localparam int unsigned FLAG_MB_BIT  = 2;

  // force strobe fields
  localparam int unsigned FORCE_A_BIT = 0;
  localparam int unsigned FORCE_B_BIT = 1;

  // port word fields
  localparam int unsigned PORT_OUTA_BIT = 0;
  localparam int unsigned PORT_OUTB_BIT = 1;
  localparam int unsigned PORT_DIRA_BIT = 2;
  localparam int unsigned PORT_DIRB_BIT = 3;
  localparam int unsigned PORT_OCSA_BIT = 4;
  localparam int unsigned PORT_OCSB_BIT = 5;

  // waveform generation select codes
  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_CTC_CMPA = 4'h4;
  localparam logic [3:0] WGM_CTC_CAPT = 4'hc;

  // output action select codes in non-pwm modes
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // counter limits and reset values
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
  localparam logic [15:0] VAL_RST      = 16'h0000;
  localparam logic [3:0]  WGM_RST      = 4'h0;
  localparam logic [1:0]  ACT_RST      = 2'h0;
  localparam logic [2:0]  FLAG_RST     = 3'h0;
  localparam logic [3:0]  PORT_RST     = 4'h0;
  localparam logic        OCS_RST      = 1'b0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic is_non_pwm(input logic [3:0] wgm);
    is_non_pwm = (wgm == WGM_NORMAL) || (wgm == WGM_CTC_CMPA) ||
                 (wgm == WGM_CTC_CAPT);
  endfunction : is_non_pwm

endpackage : tmr_pkg

// ----------------------------------------------------------------------------
// one compare channel with its output state register
// ----------------------------------------------------------------------------
module tmr_chan (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       tick_i,
  input  wire logic       equal_i,
  input  wire logic       block_i,
  input  wire logic [1:0] action_i,
  input  wire logic       non_pwm_i,
  input  wire logic       force_i,
  output logic            match_o,
  output logic            state_o
);

  logic state_reg;
  logic state_next;
  logic apply;

  always_comb begin
    match_o    = tick_i && equal_i && !block_i;
    apply      = non_pwm_i && (match_o || force_i);
    state_next = state_reg;
    if (apply) begin
      case (action_i)
        tmr_pkg::ACT_TOGGLE: state_next = !state_reg;
        tmr_pkg::ACT_CLEAR:  state_next = 1'b0;
        tmr_pkg::ACT_SET:    state_next = 1'b1;
        default:             state_next = state_reg;
      endcase
    end
  end

  // mode changes never touch this register
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= tmr_pkg::OCS_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg;

endmodule : tmr_chan

// file: tmr_top.sv
// The AXI4-Lite register port and the register addresses were left to the implementer.
module tmr_top (
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        ovf_ack_i,
  output logic             overflow_flag_o,
  output logic             match_flag_a_o,
  output logic             match_flag_b_o,
  output logic             pin_a_o,
  output logic             pin_a_oe_n_o,
  output logic             pin_b_o,
  output logic             pin_b_oe_n_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic        aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [7:0]  waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic        awready_reg, awready_next, wready_reg, wready_next;
  logic        bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  logic [3:0]  wgm_reg, wgm_next;
  logic [1:0]  act_a_reg, act_a_next, act_b_reg, act_b_next;
  logic        run_reg, run_next, block_reg, block_next;
  logic [15:0] count_reg, count_next, cmpa_reg, cmpa_next;
  logic [15:0] cmpb_reg, cmpb_next, capt_reg, capt_next;
  logic [2:0]  flag_reg, flag_next, flag_set, flag_clr;
  logic [3:0]  port_reg, port_next;
  logic        pin_a_reg, pin_a_next, pin_b_reg, pin_b_next;
  logic        oe_a_n_reg, oe_a_n_next, oe_b_n_reg, oe_b_n_next;

  logic        wr_go, cnt_wr, non_pwm, top_hit;
  logic        force_a, force_b, hit_a, hit_b, ocs_a, ocs_b;
  logic [31:0] wr_word;

  // --------------------------------------------------------------------------
  // register access helpers
  // --------------------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr[7:5] == tmr_pkg::OFF_HIGH_ZERO);
  endfunction : is_mapped

  function automatic logic [31:0] reg_read(input logic [7:0] addr);
    logic [7:0] a;
    a = {addr[7:2], 2'b00};
    case (a)
      tmr_pkg::OFF_CTRL:  reg_read = {23'h0, run_reg, act_b_reg, act_a_reg,
                                      wgm_reg};
      tmr_pkg::OFF_COUNT: reg_read = {16'h0, count_reg};
      tmr_pkg::OFF_CMPA:  reg_read = {16'h0, cmpa_reg};
      tmr_pkg::OFF_CMPB:  reg_read = {16'h0, cmpb_reg};
      tmr_pkg::OFF_CAPT:  reg_read = {16'h0, capt_reg};
      tmr_pkg::OFF_FLAGS: reg_read = {29'h0, flag_reg};
      tmr_pkg::OFF_PORT:  reg_read = {26'h0, ocs_b, ocs_a, port_reg};
      default:            reg_read = 32'h0;
    endcase
  endfunction : reg_read

  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? new_word[i*8 +: 8] : old_word[i*8 +: 8];
    end
  endfunction : merge

  // --------------------------------------------------------------------------
  // axi4-lite slave
  // --------------------------------------------------------------------------
  // a write lands one cycle after both address and data are held
  assign wr_go   = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_word = merge(reg_read(waddr_reg), wdata_reg, wstrb_reg);

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    waddr_next   = waddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid_i && awready_reg) begin
      aw_full_next = 1'b1;
      waddr_next   = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata_i;
      wstrb_next  = s_axi_wstrb_i;
    end
    if (wr_go) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = is_mapped(waddr_reg) ? tmr_pkg::RESP_OKAY
                                          : tmr_pkg::RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = reg_read(s_axi_araddr_i);
      rresp_next  = is_mapped(s_axi_araddr_i) ? tmr_pkg::RESP_OKAY
                                              : tmr_pkg::RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    awready_next = !aw_full_next && !bvalid_next;
    wready_next  = !w_full_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= tmr_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= tmr_pkg::RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      waddr_reg   <= waddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // --------------------------------------------------------------------------
  // compare channels
  // --------------------------------------------------------------------------
  assign non_pwm = tmr_pkg::is_non_pwm(wgm_reg);
  assign cnt_wr  = wr_go && (waddr_reg[7:2] == tmr_pkg::OFF_COUNT[7:2]);
  assign force_a = wr_go && (waddr_reg[7:2] == tmr_pkg::OFF_FORCE[7:2]) &&
                   wr_word[tmr_pkg::FORCE_A_BIT];
  assign force_b = wr_go && (waddr_reg[7:2] == tmr_pkg::OFF_FORCE[7:2]) &&
                   wr_word[tmr_pkg::FORCE_B_BIT];

  tmr_chan u_chan_a (
    .clock_i   (clock_i),
    .rstn_i    (rstn_i),
    .tick_i    (run_reg),
    .equal_i   (count_reg == cmpa_reg),
    .block_i   (block_reg),
    .action_i  (act_a_reg),
    .non_pwm_i (non_pwm),
    .force_i   (force_a),
    .match_o   (hit_a),
    .state_o   (ocs_a)
  );

  tmr_chan u_chan_b (
    .clock_i   (clock_i),
    .rstn_i    (rstn_i),
    .tick_i    (run_reg),
    .equal_i   (count_reg == cmpb_reg),
    .block_i   (block_reg),
    .action_i  (act_b_reg),
    .non_pwm_i (non_pwm),
    .force_i   (force_b),
    .match_o   (hit_b),
    .state_o   (ocs_b)
  );

  // --------------------------------------------------------------------------
  // counter, flags and register file
  // --------------------------------------------------------------------------
  always_comb begin
    wgm_next   = wgm_reg;
    act_a_next = act_a_reg;
    act_b_next = act_b_reg;
    run_next   = run_reg;
    cmpa_next  = cmpa_reg;
    cmpb_next  = cmpb_reg;
    capt_next  = capt_reg;
    port_next  = port_reg;
    flag_clr   = 3'h0;
    if (wr_go) begin
      case ({waddr_reg[7:2], 2'b00})
        tmr_pkg::OFF_CTRL: begin
          wgm_next   = wr_word[tmr_pkg::CTRL_WGM_LSB +: 4];
          act_a_next = wr_word[tmr_pkg::CTRL_ACTA_LSB +: 2];
          act_b_next = wr_word[tmr_pkg::CTRL_ACTB_LSB +: 2];
          run_next   = wr_word[tmr_pkg::CTRL_RUN_BIT];
        end
        tmr_pkg::OFF_CMPA:  cmpa_next = wr_word[15:0];
        tmr_pkg::OFF_CMPB:  cmpb_next = wr_word[15:0];
        // only software loads it; action bits play no part
        tmr_pkg::OFF_CAPT:  capt_next = wr_word[15:0];
        tmr_pkg::OFF_FLAGS: flag_clr  = wr_word[2:0];
        tmr_pkg::OFF_PORT:  port_next = wr_word[3:0];
        default:            flag_clr  = 3'h0;
      endcase
    end
    // a blocked top match is simply missed; the count runs on past it
    case (wgm_reg)
      tmr_pkg::WGM_CTC_CMPA: top_hit = hit_a;
      tmr_pkg::WGM_CTC_CAPT: top_hit = run_reg && !block_reg &&
                                       (count_reg == capt_reg);
      default:               top_hit = 1'b0;
    endcase
    count_next = count_reg;
    if (cnt_wr) begin
      count_next = wr_word[15:0];
    end else if (run_reg) begin
      count_next = top_hit ? tmr_pkg::COUNT_BOTTOM
                           : 16'(count_reg + 16'h0001);
    end
    // block lasts until the next timer tick, stopped or not
    block_next = cnt_wr ? 1'b1 : (run_reg ? 1'b0 : block_reg);
    flag_set = 3'h0;
    flag_set[tmr_pkg::FLAG_OVF_BIT] = run_reg && !cnt_wr &&
                                      (count_reg == tmr_pkg::COUNT_MAX);
    flag_set[tmr_pkg::FLAG_MA_BIT] = hit_a;
    flag_set[tmr_pkg::FLAG_MB_BIT] = hit_b;
    flag_clr[tmr_pkg::FLAG_OVF_BIT] = flag_clr[tmr_pkg::FLAG_OVF_BIT] ||
                                      ovf_ack_i;
    // a set in the clearing cycle wins
    flag_next = (flag_reg & ~flag_clr) | flag_set;
    pin_a_next  = (act_a_reg != tmr_pkg::ACT_NONE) ? ocs_a
                  : port_reg[tmr_pkg::PORT_OUTA_BIT];
    pin_b_next  = (act_b_reg != tmr_pkg::ACT_NONE) ? ocs_b
                  : port_reg[tmr_pkg::PORT_OUTB_BIT];
    oe_a_n_next = !port_reg[tmr_pkg::PORT_DIRA_BIT];
    oe_b_n_next = !port_reg[tmr_pkg::PORT_DIRB_BIT];
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wgm_reg    <= tmr_pkg::WGM_RST;
      act_a_reg  <= tmr_pkg::ACT_RST;
      act_b_reg  <= tmr_pkg::ACT_RST;
      run_reg    <= 1'b0;
      block_reg  <= 1'b0;
      count_reg  <= tmr_pkg::VAL_RST;
      cmpa_reg   <= tmr_pkg::VAL_RST;
      cmpb_reg   <= tmr_pkg::VAL_RST;
      capt_reg   <= tmr_pkg::VAL_RST;
      flag_reg   <= tmr_pkg::FLAG_RST;
      port_reg   <= tmr_pkg::PORT_RST;
      pin_a_reg  <= 1'b0;
      pin_b_reg  <= 1'b0;
      oe_a_n_reg <= 1'b1;
      oe_b_n_reg <= 1'b1;
    end else begin
      wgm_reg    <= wgm_next;
      act_a_reg  <= act_a_next;
      act_b_reg  <= act_b_next;
      run_reg    <= run_next;
      block_reg  <= block_next;
      count_reg  <= count_next;
      cmpa_reg   <= cmpa_next;
      cmpb_reg   <= cmpb_next;
      capt_reg   <= capt_next;
      flag_reg   <= flag_next;
      port_reg   <= port_next;
      pin_a_reg  <= pin_a_next;
      pin_b_reg  <= pin_b_next;
      oe_a_n_reg <= oe_a_n_next;
      oe_b_n_reg <= oe_b_n_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign overflow_flag_o = flag_reg[tmr_pkg::FLAG_OVF_BIT];
  assign match_flag_a_o  = flag_reg[tmr_pkg::FLAG_MA_BIT];
  assign match_flag_b_o  = flag_reg[tmr_pkg::FLAG_MB_BIT];
  assign pin_a_o         = pin_a_reg;
  assign pin_a_oe_n_o    = oe_a_n_reg;
  assign pin_b_o         = pin_b_reg;
  assign pin_b_oe_n_o    = oe_b_n_reg;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  a_block_match: assert property (
    (block_reg && !match_flag_a_o) |=> !match_flag_a_o)
    else $error("match flag set while blocked");
  a_ctc_missed_top: assert property (
    (run_reg && block_reg && !cnt_wr && wgm_reg == tmr_pkg::WGM_CTC_CMPA &&
     count_reg == cmpa_reg && count_reg != tmr_pkg::COUNT_MAX)
    |=> count_reg == 16'($past(count_reg) + 16'h0001))
    else $error("blocked top match still cleared counter");
  a_zero_action_hold: assert property (
    (act_a_reg == tmr_pkg::ACT_NONE) |=> $stable(ocs_a))
    else $error("output state moved with action zero");
  a_toggle_on_match: assert property (
    (hit_a && non_pwm && act_a_reg == tmr_pkg::ACT_TOGGLE && !force_a)
    |=> ocs_a != $past(ocs_a))
    else $error("toggle action missed on match");
  a_force_no_flag: assert property (
    (force_a && !hit_a && !top_hit && !match_flag_a_o && !cnt_wr)
    |=> !match_flag_a_o && count_reg == $past(count_reg) +
        16'($past(run_reg)))
    else $error("force touched flag or counter");
  a_force_apply_set: assert property (
    (force_a && non_pwm && act_a_reg == tmr_pkg::ACT_SET) |=> ocs_a)
    else $error("force set did not apply");
  a_pin_override: assert property (
    (act_a_reg != tmr_pkg::ACT_NONE) |=> pin_a_o == $past(ocs_a))
    else $error("pin not driven by output state");
  a_pin_direction: assert property (
    ##1 pin_b_oe_n_o == !$past(port_reg[tmr_pkg::PORT_DIRB_BIT]))
    else $error("pin enable does not follow direction bit");
  a_ovf_on_wrap: assert property (
    (run_reg && !cnt_wr && count_reg == tmr_pkg::COUNT_MAX)
    |=> overflow_flag_o && count_reg == tmr_pkg::COUNT_BOTTOM)
    else $error("wrap without overflow flag");
  a_ctc_clear: assert property (
    (top_hit && !cnt_wr) |=> count_reg == tmr_pkg::COUNT_BOTTOM)
    else $error("clear-on-match did not restart count");
  a_match_flag: assert property (hit_b |=> match_flag_b_o)
    else $error("match flag not set after equality");

  c_ctc_wrap:   cover property (top_hit && wgm_reg == tmr_pkg::WGM_CTC_CAPT);
  c_overflow:   cover property ($rose(overflow_flag_o));
  c_forced:     cover property (force_a && act_a_reg == tmr_pkg::ACT_TOGGLE);
  c_blocked_eq: cover property (run_reg && block_reg &&
                                count_reg == cmpa_reg);

endmodule : tmr_top

// file: tmr_pin_model.sv
module tmr_pin_model (
  input  wire logic pin_i,
  input  wire logic oe_n_i,
  output logic      level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // released pin falls to the board pull-down, never keeps the last value
  assign level_o = oe_n_i ? 1'b0 : pin_i;
endmodule : tmr_pin_model

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rstn, awvalid, wvalid, bready, arvalid, rready, ack;
  logic        awready, wready, bvalid, arready, rvalid, ovf, mfa, mfb;
  logic        pa, pa_oe_n, pb, pb_oe_n, lvl_a, lvl_b;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, b_seen;
  int          num_errors, samples_checked;

  tmr_top u_tmr_top (.clock_i(clock), .rstn_i(rstn),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ovf_ack_i(ack),
    .overflow_flag_o(ovf), .match_flag_a_o(mfa), .match_flag_b_o(mfb),
    .pin_a_o(pa), .pin_a_oe_n_o(pa_oe_n), .pin_b_o(pb), .pin_b_oe_n_o(pb_oe_n));
  tmr_pin_model u_tmr_pin_model (.pin_i(pa), .oe_n_i(pa_oe_n), .level_o(lvl_a));
  tmr_pin_model u_pin_b (.pin_i(pb), .oe_n_i(pb_oe_n), .level_o(lvl_b));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // a wait that runs out counts as a mismatch and ends the run
  task automatic tmo;
    chk(32'h0, 32'h1);
    summarize();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    b_seen = bresp;
    if (n == 40) tmo();
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_val = rdata;
    if (n == 40) tmo();
    chk(rd_val & m, e);
  endtask : rdchk

  task automatic wait_hi(ref logic s);
    int n;
    for (n = 0; n < 300 && s !== 1'b1; n++) @(posedge clock);
    if (n == 300) tmo();
  endtask : wait_hi

  task automatic t_force;
    chk({pa_oe_n, lvl_a}, 32'h2);
    rdchk(tmr_pkg::OFF_PORT, 32'h30, 32'h0);
    wr(tmr_pkg::OFF_CTRL, 32'h30);
    wr(tmr_pkg::OFF_FORCE, 32'h1);
    rdchk(tmr_pkg::OFF_PORT, 32'h10, 32'h10);
    rdchk(tmr_pkg::OFF_COUNT, 32'hffff, 32'h0);
    chk(32'(mfa), 32'h0);
    chk(32'(lvl_a), 32'h0);
    wr(tmr_pkg::OFF_PORT, 32'he);
    repeat (2) @(posedge clock);
    chk(32'(lvl_a), 32'h1);
    chk({pb_oe_n, lvl_b}, 32'h1);
    wr(tmr_pkg::OFF_CTRL, 32'h04);
    repeat (2) @(posedge clock);
    chk(32'(lvl_a), 32'h0);
    rdchk(tmr_pkg::OFF_PORT, 32'h10, 32'h10);
    $display("force and pin test done");
  endtask : t_force

  task automatic t_ctc;
    wr(tmr_pkg::OFF_CMPA, 32'h20);
    wr(tmr_pkg::OFF_CTRL, 32'h104);
    wait_hi(mfa);
    rdchk(tmr_pkg::OFF_PORT, 32'h10, 32'h10);
    wr(tmr_pkg::OFF_CTRL, 32'h114);
    wr(tmr_pkg::OFF_FLAGS, 32'h7);
    wait_hi(mfa);
    rdchk(tmr_pkg::OFF_PORT, 32'h10, 32'h0);
    rdchk(tmr_pkg::OFF_COUNT, 32'hffff, 32'h3);
    chk(32'(rd_val[15:0] < 16'h20), 32'h1);
    // a count write onto top hides that match; the count runs on
    wr(tmr_pkg::OFF_COUNT, 32'h20);
    rdchk(tmr_pkg::OFF_COUNT, 32'hffff, 32'h21);
    $display("clear on match test done");
  endtask : t_ctc

  task automatic t_capt;
    wr(tmr_pkg::OFF_CAPT, 32'h10);
    wr(tmr_pkg::OFF_CMPA, 32'h8);
    wr(tmr_pkg::OFF_CTRL, 32'h3c);
    wr(tmr_pkg::OFF_FORCE, 32'h1);
    rdchk(tmr_pkg::OFF_PORT, 32'h10, 32'h10);
    // bottom is loaded while stopped, before the count is started
    wr(tmr_pkg::OFF_COUNT, 32'h0);
    wr(tmr_pkg::OFF_FLAGS, 32'h7);
    wr(tmr_pkg::OFF_CTRL, 32'h12c);
    wait_hi(mfa);
    rdchk(tmr_pkg::OFF_PORT, 32'h10, 32'h0);
    repeat (6) @(posedge clock);
    rdchk(tmr_pkg::OFF_COUNT, 32'hffff, 32'h1);
    rdchk(tmr_pkg::OFF_CAPT, 32'hffff, 32'h10);
    $display("capture top test done");
  endtask : t_capt

  task automatic t_block_ovf;
    wr(tmr_pkg::OFF_CTRL, 32'h100);
    wr(tmr_pkg::OFF_CMPB, 32'h100);
    wr(tmr_pkg::OFF_FLAGS, 32'h7);
    wr(tmr_pkg::OFF_COUNT, 32'h100);
    repeat (3) @(posedge clock);
    chk(32'(mfb), 32'h0);
    wr(tmr_pkg::OFF_COUNT, 32'hfff0);
    chk(32'(ovf), 32'h0);
    wait_hi(ovf);
    rdchk(tmr_pkg::OFF_COUNT, 32'hffff, 32'h1);
    chk(32'(rd_val[15:0] < 16'h10), 32'h1);
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    @(posedge clock);
    chk(32'(ovf), 32'h0);
    rdchk(8'h40, 32'hffffffff, 32'h0);
    chk(32'(rresp), 32'(tmr_pkg::RESP_SLVERR));
    wr(8'h40, 32'h1);
    chk(32'(b_seen), 32'(tmr_pkg::RESP_SLVERR));
    $display("blocking and overflow test done");
  endtask : t_block_ovf

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, ack} = 7'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_force();
    t_ctc();
    t_capt();
    t_block_ovf();
    summarize();
  end
endmodule : tb
